/* File: console_pkg.sv */
// shared constants and types for the console key decoder
package console_pkg;
    // key bit positions within the key vector
    localparam int KEY_COUNT       = 8;
    localparam int K_RECIPE        = 0;
    localparam int K_START_PAUSE   = 1;
    localparam int K_VIEW          = 2;
    localparam int K_SHIFT         = 3;
    localparam int K_ERASE         = 4;
    localparam int K_CONFIRM       = 5;
    localparam int K_SETTINGS      = 6;
    localparam int K_AUX           = 7;
    // program number width and reset value
    localparam int RECIPE_KEY_W          = 4;
    localparam logic [3:0] RECIPE_KEY_RESET = 4'h0;
    // program operating modes
    typedef enum logic [2:0] {
        MODE_READY,
        MODE_RUN,
        MODE_HOLD,
        MODE_FAST,
        MODE_END
    } recipe_key_mode_t;
    // screens of the console
    typedef enum logic [2:0] {
        SCR_BASIC,
        SCR_PARAM,
        SCR_RECIPE_KEY_SETUP,
        SCR_SEG_EDIT,
        SCR_COPY,
        SCR_GRESET
    } screen_t;
endpackage

/* File: key_edge.sv */
// registers the key vector and flags newly pressed keys
`timescale 1ns/1ps
`default_nettype none
module key_edge #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    // keys
    input  wire logic [WIDTH-1:0] i_keys,
    output logic      [WIDTH-1:0] o_held,
    output logic      [WIDTH-1:0] o_press
);
    logic [WIDTH-1:0] held_reg;
    logic [WIDTH-1:0] held_next;
    logic [WIDTH-1:0] press_reg;
    logic [WIDTH-1:0] press_next;

    always_comb begin
        held_next = i_keys;
        for (int b = 0; b < WIDTH; b++) begin
            press_next[b] = i_keys[b] & ~held_reg[b];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held_reg  <= '0;
            press_reg <= '0;
        end else begin
            held_reg  <= held_next;
            press_reg <= press_next;
        end
    end

    assign o_held  = held_reg;
    assign o_press = press_reg;
endmodule
`default_nettype wire

/* File: recipe_key_counter.sv */
// wrapping up/down counter for the program being edited
`timescale 1ns/1ps
`default_nettype none
module recipe_key_counter #(
    parameter int W = 4
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // steps
    input  wire logic         i_inc,
    input  wire logic         i_dec,
    output logic      [W-1:0] o_count
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // wraps both ways; simultaneous steps cancel
    always_comb begin
        cnt_next = cnt_reg;
        if (i_inc && !i_dec) begin
            cnt_next = cnt_reg + W'(1);
        end else if (i_dec && !i_inc) begin
            cnt_next = cnt_reg - W'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= W'(console_pkg::RECIPE_KEY_RESET);
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign o_count = cnt_reg;
endmodule
`default_nettype wire

/* File: console_ctrl.sv */
// front-panel key combination decoder and program mode controller
`timescale 1ns/1ps
`default_nettype none
module console_ctrl (
    // clock and reset
    input  wire logic                             i_ref_clk,
    input  wire logic                             i_rst_n,
    // console keys, one bit per key, high while pressed
    input  wire logic [console_pkg::KEY_COUNT-1:0] i_keys,
    // state from the rest of the controller
    input  wire logic                             i_auto_mode,
    input  wire logic                             i_entry_active,
    input  wire logic                             i_cursor_setpoint_time,
    input  wire logic                             i_dest_blink,
    input  wire logic                             i_exit_screen,
    input  wire logic                             i_run_hold_req,
    input  wire logic                             i_program_done,
    // status
    output logic [2:0]                            o_mode,
    output logic [2:0]                            o_screen,
    output logic [console_pkg::RECIPE_KEY_W-1:0]        o_recipe_key_no,
    // one-cycle action pulses
    output logic                                  o_seg_advance,
    output logic                                  o_clear_item,
    output logic                                  o_copy_exec,
    output logic                                  o_general_reset
);
    logic [console_pkg::KEY_COUNT-1:0] held;
    logic [console_pkg::KEY_COUNT-1:0] press;
    logic [console_pkg::RECIPE_KEY_W-1:0]    recipe_key_cnt;

    console_pkg::recipe_key_mode_t mode_reg;
    console_pkg::recipe_key_mode_t mode_next;
    console_pkg::screen_t    screen_reg;
    console_pkg::screen_t    screen_next;
    logic                    adv_reg;
    logic                    adv_next;
    logic                    clr_reg;
    logic                    clr_next;
    logic                    copy_reg;
    logic                    copy_next;
    logic                    greset_reg;
    logic                    greset_next;
    logic [console_pkg::RECIPE_KEY_W-1:0] recipe_key_reg;
    logic                    inc;
    logic                    dec;

    // =========================================================
    // key capture
    key_edge #(
        .WIDTH (console_pkg::KEY_COUNT)
    ) u_key_edge (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_keys    (i_keys),
        .o_held    (held),
        .o_press   (press)
    );

    // =========================================================
    // combination decode
    logic shift_h;
    logic recipe_h;
    logic in_basic;
    logic in_setup;
    logic is_ready;
    logic combo_reset;
    logic combo_adv;
    logic combo_fast;
    logic combo_param;
    logic combo_setup;
    logic combo_inc;
    logic combo_dec;
    logic combo_clr;
    logic combo_seg;
    logic combo_copy;
    logic combo_greset;

    // combo decode
    // a modifier only counts when held before the second key's press edge; in the general reset combo erase and view may rise together
    always_comb begin
        shift_h      = held[console_pkg::K_SHIFT] & ~press[console_pkg::K_SHIFT];
        recipe_h     = held[console_pkg::K_RECIPE] & ~press[console_pkg::K_RECIPE];
        in_basic     = (screen_reg == console_pkg::SCR_BASIC);
        in_setup     = (screen_reg == console_pkg::SCR_RECIPE_KEY_SETUP);
        is_ready     = (mode_reg == console_pkg::MODE_READY);
        combo_reset  = recipe_h & press[console_pkg::K_START_PAUSE];
        combo_adv    = recipe_h & press[console_pkg::K_VIEW];
        combo_fast   = shift_h & press[console_pkg::K_AUX];
        combo_param  = shift_h & press[console_pkg::K_SETTINGS];
        combo_setup  = shift_h & press[console_pkg::K_RECIPE];
        combo_inc    = combo_setup;
        combo_dec    = combo_fast;
        combo_greset = shift_h & ((press[console_pkg::K_ERASE] & held[console_pkg::K_VIEW])
                                | (press[console_pkg::K_VIEW] & held[console_pkg::K_ERASE]));
        combo_clr    = shift_h & press[console_pkg::K_ERASE] & ~held[console_pkg::K_VIEW];
        combo_seg    = shift_h & press[console_pkg::K_CONFIRM];
        // copy: aux modifier held, then recipe pressed
        combo_copy   = held[console_pkg::K_AUX] & ~press[console_pkg::K_AUX]
                     & press[console_pkg::K_RECIPE] & ~shift_h;
    end

    // =========================================================
    // mode and screen machine
    always_comb begin
        mode_next   = mode_reg;
        screen_next = screen_reg;
        adv_next    = 1'b0;
        clr_next    = 1'b0;
        copy_next   = 1'b0;
        greset_next = 1'b0;
        inc         = 1'b0;
        dec         = 1'b0;
        unique case (screen_reg)
            console_pkg::SCR_BASIC: begin
                if (combo_reset) begin
                    if (!is_ready) begin
                        mode_next = console_pkg::MODE_READY;
                    end
                end else if (combo_adv) begin
                    if (!is_ready && mode_reg != console_pkg::MODE_END) begin
                        adv_next = 1'b1;
                    end
                end else if (combo_greset) begin
                    if (is_ready && i_auto_mode) begin
                        screen_next = console_pkg::SCR_GRESET;
                    end
                end else if (combo_fast) begin
                    if (mode_reg == console_pkg::MODE_RUN || mode_reg == console_pkg::MODE_HOLD) begin
                        mode_next = console_pkg::MODE_FAST;
                    end
                end else if (combo_param) begin
                    screen_next = console_pkg::SCR_PARAM;
                end else if (combo_setup) begin
                    screen_next = console_pkg::SCR_RECIPE_KEY_SETUP;
                end else if (combo_copy) begin
                    if (is_ready) begin
                        screen_next = console_pkg::SCR_COPY;
                    end
                end else if (i_run_hold_req) begin
                    unique case (mode_reg)
                        console_pkg::MODE_RUN:  mode_next = console_pkg::MODE_HOLD;
                        console_pkg::MODE_END:  mode_next = mode_reg;
                        default:                mode_next = console_pkg::MODE_RUN;
                    endcase
                end
            end
            console_pkg::SCR_RECIPE_KEY_SETUP: begin
                if (combo_inc) begin
                    inc = 1'b1;
                end else if (combo_dec) begin
                    dec = 1'b1;
                end else if (combo_clr && i_entry_active) begin
                    clr_next = 1'b1;
                end else if (combo_seg && i_cursor_setpoint_time) begin
                    screen_next = console_pkg::SCR_SEG_EDIT;
                end else if (i_exit_screen) begin
                    screen_next = console_pkg::SCR_BASIC;
                end
            end
            console_pkg::SCR_SEG_EDIT: begin
                if (i_exit_screen) begin
                    screen_next = console_pkg::SCR_RECIPE_KEY_SETUP;
                end
            end
            console_pkg::SCR_COPY: begin
                if (press[console_pkg::K_CONFIRM] && i_dest_blink) begin
                    copy_next = 1'b1;
                end else if (i_exit_screen) begin
                    screen_next = console_pkg::SCR_BASIC;
                end
            end
            console_pkg::SCR_GRESET: begin
                if (press[console_pkg::K_CONFIRM]) begin
                    greset_next = 1'b1;
                    screen_next = console_pkg::SCR_BASIC;
                end else if (i_exit_screen) begin
                    screen_next = console_pkg::SCR_BASIC;
                end
            end
            console_pkg::SCR_PARAM: begin
                if (i_exit_screen) begin
                    screen_next = console_pkg::SCR_BASIC;
                end
            end
            default: screen_next = console_pkg::SCR_BASIC;
        endcase
        // program finishing is outside the key path; a key reset still wins
        if (i_program_done && mode_next != console_pkg::MODE_READY && !is_ready) begin
            mode_next = console_pkg::MODE_END;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg   <= console_pkg::MODE_READY;
            screen_reg <= console_pkg::SCR_BASIC;
            adv_reg    <= 1'b0;
            clr_reg    <= 1'b0;
            copy_reg   <= 1'b0;
            greset_reg <= 1'b0;
            recipe_key_reg   <= console_pkg::RECIPE_KEY_RESET;
        end else begin
            mode_reg   <= mode_next;
            screen_reg <= screen_next;
            adv_reg    <= adv_next;
            clr_reg    <= clr_next;
            copy_reg   <= copy_next;
            greset_reg <= greset_next;
            recipe_key_reg   <= recipe_key_cnt;
        end
    end

    // =========================================================
    // program number counter
    recipe_key_counter #(
        .W (console_pkg::RECIPE_KEY_W)
    ) u_recipe_key_counter (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_inc     (inc),
        .i_dec     (dec),
        .o_count   (recipe_key_cnt)
    );

    assign o_mode          = mode_reg;
    assign o_screen        = screen_reg;
    assign o_recipe_key_no       = recipe_key_reg;
    assign o_seg_advance   = adv_reg;
    assign o_clear_item    = clr_reg;
    assign o_copy_exec     = copy_reg;
    assign o_general_reset = greset_reg;

    // =========================================================
    // checks
    // no reset from ready
    a_ready_reset_ignored: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (screen_reg == console_pkg::SCR_BASIC && mode_reg == console_pkg::MODE_READY && combo_reset)
        |=> mode_reg == console_pkg::MODE_READY) else $error("reset combo changed ready mode");
    a_reset_to_ready: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (screen_reg == console_pkg::SCR_BASIC && combo_reset) |=> mode_reg == console_pkg::MODE_READY)
        else $error("reset combo did not reach ready");
    a_no_adv_ready: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_seg_advance |-> $past(mode_reg) != console_pkg::MODE_READY) else $error("advance in ready");
    a_adv_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (in_basic && combo_adv && (mode_reg == console_pkg::MODE_RUN || mode_reg == console_pkg::MODE_HOLD))
        |=> o_seg_advance ##1 !o_seg_advance) else $error("advance pulse wrong");
    // fast only from run or hold
    a_fast_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_reg == console_pkg::MODE_FAST && $past(mode_reg) != console_pkg::MODE_FAST)
        |-> ($past(mode_reg) == console_pkg::MODE_RUN || $past(mode_reg) == console_pkg::MODE_HOLD))
        else $error("fast entered from wrong mode");
    a_copy_ready: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (screen_reg == console_pkg::SCR_COPY && $past(screen_reg) == console_pkg::SCR_BASIC)
        |-> $past(mode_reg) == console_pkg::MODE_READY) else $error("copy screen outside ready");
    a_greset_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (screen_reg == console_pkg::SCR_GRESET && $past(screen_reg) != console_pkg::SCR_GRESET)
        |-> ($past(mode_reg) == console_pkg::MODE_READY && $past(i_auto_mode)))
        else $error("general reset screen entered wrongly");
    a_greset_exec: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (screen_reg == console_pkg::SCR_GRESET && press[console_pkg::K_CONFIRM])
        |=> o_general_reset && screen_reg == console_pkg::SCR_BASIC) else $error("general reset not done");
    a_recipe_key_inc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (in_setup && combo_inc) |=> ##1 o_recipe_key_no == $past(o_recipe_key_no) + 4'h1)
        else $error("program number not incremented");
    a_copy_exec: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (screen_reg == console_pkg::SCR_COPY && press[console_pkg::K_CONFIRM] && i_dest_blink)
        |=> o_copy_exec) else $error("copy not executed");
endmodule
`default_nettype wire

/* File: console_operator.sv */
// operator model pressing front-panel key combinations
`timescale 1ns/1ps
`default_nettype none
module console_operator (
    // clock
    input  wire logic       i_ref_clk,
    // key levels toward the console
    output var  logic [7:0] o_keys
);
    initial o_keys = 8'h00;

    task automatic combo(input logic [7:0] mods, input logic [7:0] keys);
        @(negedge i_ref_clk);
        o_keys = mods;
        // modifier must stand a full cycle before the key rises
        repeat (2) @(negedge i_ref_clk);
        o_keys = mods | keys;
        repeat (4) @(negedge i_ref_clk);
        o_keys = 8'h00;
        repeat (4) @(negedge i_ref_clk);
    endtask

    // modifier rising with the key must not count
    task automatic together(input logic [7:0] keys);
        @(negedge i_ref_clk);
        o_keys = keys;
        repeat (4) @(negedge i_ref_clk);
        o_keys = 8'h00;
        repeat (4) @(negedge i_ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: console_ctrl_tb.sv */
// self-checking bench for the console key decoder
`timescale 1ns/1ps
`default_nettype none
module console_ctrl_tb;
    // ==========================================
    // stimulus, outputs and expected state
    localparam logic [7:0] KR  = 8'(1 << console_pkg::K_RECIPE);
    localparam logic [7:0] KSP = 8'(1 << console_pkg::K_START_PAUSE);
    localparam logic [7:0] KV  = 8'(1 << console_pkg::K_VIEW);
    localparam logic [7:0] KSH = 8'(1 << console_pkg::K_SHIFT);
    localparam logic [7:0] KE  = 8'(1 << console_pkg::K_ERASE);
    localparam logic [7:0] KC  = 8'(1 << console_pkg::K_CONFIRM);
    localparam logic [7:0] KS  = 8'(1 << console_pkg::K_SETTINGS);
    localparam logic [7:0] KA  = 8'(1 << console_pkg::K_AUX);
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  keys;
    logic        auto_mode = 1'b1;
    logic        entry_active = 1'b0;
    logic        cursor_setpoint_time = 1'b0;
    logic        dest_blink = 1'b0;
    logic        exit_screen = 1'b0;
    logic        run_hold_req = 1'b0;
    logic        program_done = 1'b0;
    logic [2:0]  o_mode;
    logic [2:0]  o_screen;
    logic [3:0]  o_recipe_key_no;
    logic        o_seg_advance, o_clear_item, o_copy_exec, o_general_reset;
    logic [7:0]  cseg, cclr, ccpy, cgr;
    logic [15:0] seed = 16'h4321;
    int          em = 0, es = 0, ep = 0, eseg = 0, eclr = 0, ecpy = 0, egr = 0;
    int          failures = 0;
    int          compares = 0;
    int          n;

    always #2.5 ref_clk = ~ref_clk;

    console_operator i_console_operator (.i_ref_clk(ref_clk), .o_keys(keys));

    console_ctrl i_console_ctrl (
        .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_keys(keys), .i_auto_mode(auto_mode),
        .i_entry_active(entry_active), .i_cursor_setpoint_time(cursor_setpoint_time),
        .i_dest_blink(dest_blink), .i_exit_screen(exit_screen), .i_run_hold_req(run_hold_req),
        .i_program_done(program_done), .o_mode(o_mode), .o_screen(o_screen), .o_recipe_key_no(o_recipe_key_no),
        .o_seg_advance(o_seg_advance), .o_clear_item(o_clear_item), .o_copy_exec(o_copy_exec),
        .o_general_reset(o_general_reset)
    );

    // one-cycle pulses are counted so none slips between checks
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            {cseg, cclr, ccpy, cgr} <= 32'h00000000;
        end else begin
            cseg <= cseg + 8'(o_seg_advance);
            cclr <= cclr + 8'(o_clear_item);
            ccpy <= ccpy + 8'(o_copy_exec);
            cgr  <= cgr + 8'(o_general_reset);
        end
    end

    // ==========================================
    // helpers
    function int rnd();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return int'(seed);
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic check_all();
        check("mode", 8'(o_mode), 8'(em));
        check("screen", 8'(o_screen), 8'(es));
        check("recipe_key_no", 8'(o_recipe_key_no), 8'(ep));
        check("seg_advance", cseg, 8'(eseg));
        check("clear_item", cclr, 8'(eclr));
        check("copy_exec", ccpy, 8'(ecpy));
        check("general_reset", cgr, 8'(egr));
    endtask

    // which: 0 run/hold request, 1 program done, 2 exit screen
    task automatic pulse(input int which);
        @(negedge ref_clk);
        if (which == 0) run_hold_req = 1'b1;
        else if (which == 1) program_done = 1'b1;
        else exit_screen = 1'b1;
        @(negedge ref_clk);
        {run_hold_req, program_done, exit_screen} = 3'h0;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic results();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check_all();
        i_console_operator.combo(KR, KSP);
        check_all();
        i_console_operator.combo(KR, KV);
        check_all();
        for (int m = 1; m <= 4; m++) begin
            pulse(0);
            em = 1;
            if (m == 2) begin
                pulse(0);
                em = 2;
            end
            if (m == 3) i_console_operator.combo(KSH, KA);
            if (m == 3) em = 3;
            if (m == 4) pulse(1);
            if (m == 4) em = 4;
            check_all();
            // advance only in run, hold, fast
            eseg += (m < 4) ? 1 : 0;
            i_console_operator.combo(KR, KV);
            check_all();
            i_console_operator.combo(KA, KR);
            check_all();
            // auto flag is random here: general reset is refused outside ready anyway
            auto_mode = 1'(rnd());
            i_console_operator.combo(KSH | KE, KV);
            check_all();
            i_console_operator.combo(KSH, KA);
            em = (m == 4) ? 4 : ((m == 1) ? 3 : em);
            em = (m == 2) ? 3 : em;
            check_all();
            em = 0;
            i_console_operator.combo(KR, KSP);
            check_all();
        end
        i_console_operator.combo(KSH, KA);
        check_all();
        i_console_operator.together(KSH | KS);
        check_all();
        es = 1;
        i_console_operator.combo(KSH, KS);
        check_all();
        pulse(2);
        es = 2;
        i_console_operator.combo(KSH, KR);
        check_all();
        n = 1 + (rnd() % 20);
        for (int i = 0; i < n; i++) begin
            ep = (ep + 1) % 16;
            i_console_operator.combo(KSH, KR);
            check_all();
        end
        n = 1 + (rnd() % 20);
        for (int i = 0; i < n; i++) begin
            ep = (ep + 15) % 16;
            i_console_operator.combo(KSH, KA);
            check_all();
        end
        i_console_operator.combo(KSH, KE);
        check_all();
        entry_active = 1'b1;
        eclr = 1;
        i_console_operator.combo(KSH, KE);
        check_all();
        entry_active = 1'b0;
        i_console_operator.combo(KSH, KC);
        check_all();
        cursor_setpoint_time = 1'b1;
        es = 3;
        i_console_operator.combo(KSH, KC);
        check_all();
        cursor_setpoint_time = 1'b0;
        pulse(2);
        pulse(2);
        es = 0;
        check_all();
        es = 4;
        i_console_operator.combo(KA, KR);
        check_all();
        i_console_operator.combo(8'h00, KC);
        check_all();
        dest_blink = 1'b1;
        ecpy = 1;
        i_console_operator.combo(8'h00, KC);
        check("copy_exec", ccpy, 8'(ecpy));
        dest_blink = 1'b0;
        pulse(2);
        es = 0;
        auto_mode = 1'b0;
        i_console_operator.combo(KSH | KE, KV);
        check_all();
        auto_mode = 1'b1;
        es = 5;
        i_console_operator.combo(KSH | KE, KV);
        check_all();
        egr = 1;
        i_console_operator.combo(8'h00, KC);
        check("general_reset", cgr, 8'(egr));
        es = 0;
        check_all();
        results();
    end

    initial begin
        #200000;
        failures++;
        results();
    end
endmodule
`default_nettype wire
